/* File: shared/sacc_pkg.sv */
// Shared constants and types for the converter control block.
package sacc_pkg;
	// Converter clock cycles per input, with and without sample-and-hold.
	localparam int unsigned CYC_8B_NOSH  = 49;
	localparam int unsigned CYC_10B_NOSH = 59;
	localparam int unsigned CYC_8B_SH    = 28;
	localparam int unsigned CYC_10B_SH   = 33;
	localparam int unsigned SAMP_NOSH    = 2;
	localparam int unsigned SAMP_SH      = 3;
	// Result and selector geometry.
	localparam int unsigned RES_W        = 10;
	localparam int unsigned NUM_INPUTS   = 26;
	localparam int unsigned PORT_PINS    = 8;
	localparam logic [4:0]  EXT_IN_0_IDX = 5'h18;
	localparam logic [4:0]  EXT_IN_1_IDX = 5'h19;
	localparam logic [4:0]  SELF_TEST_IDX = 5'h1F;
	// Trigger source codes for the hardware trigger select pair.
	localparam logic [1:0]  TRG_EXT_PIN  = 2'h0;
	localparam logic [1:0]  TRG_TMR_B2   = 2'h1;
	localparam logic [1:0]  TRG_TMR_A0   = 2'h2;
	// Two-bit operating mode field codes.
	localparam logic [1:0]  MD_ONE_SHOT  = 2'h0;
	localparam logic [1:0]  MD_REPEAT    = 2'h1;
	localparam logic [1:0]  MD_SWEEP     = 2'h2;
	localparam logic [1:0]  MD_RSWEEP    = 2'h3;
	// Decoded operating mode as reported to software.
	typedef enum logic [2:0] {
		MODE_ONE_SHOT = 3'h0,
		MODE_REPEAT   = 3'h1,
		MODE_SWEEP    = 3'h2,
		MODE_RSWEEP0  = 3'h3,
		MODE_RSWEEP1  = 3'h4,
		MODE_MP_SWEEP = 3'h5,
		MODE_MP_RSW0  = 3'h6,
		MODE_SELFTEST = 3'h7
	} sacc_mode_e;
	// Engine states, one-hot.
	typedef enum logic [4:0] {
		ST_IDLE   = 5'b00001,
		ST_ARMED  = 5'b00010,
		ST_SAMPLE = 5'b00100,
		ST_CONV   = 5'b01000,
		ST_STORE  = 5'b10000
	} sacc_state_e;
endpackage

/* File: src/sacc_clk_div.sv */
// Converter clock tick generator from the source clock.
`timescale 1ns/1ps
module sacc_clk_div (
	input  wire logic core_clk_i,
	input  wire logic nrst_i,
	input  wire logic clk_div_sel_a_i,
	input  wire logic clk_div_sel_b_i,
	input  wire logic clk_div_sel_c_i,
	output logic      tick_o
);
	logic [2:0] cnt_r;
	logic [2:0] last;

	// Terminal count is the divide ratio less one; undefined high codes fall back to /8.
	always_comb begin
		unique case ({clk_div_sel_c_i, clk_div_sel_a_i, clk_div_sel_b_i})
			3'h0:    last = 3'h3;
			3'h1:    last = 3'h2;
			3'h2:    last = 3'h1;
			3'h3:    last = 3'h0;
			3'h5:    last = 3'h5;
			default: last = 3'h7;
		endcase
	end

	// A divider change keeps the count; a count at or past the new terminal value wraps at once.
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || cnt_r >= last) begin
			cnt_r <= 3'h0;
		end else begin
			cnt_r <= cnt_r + 3'h1;
		end
	end

	assign tick_o = nrst_i && (cnt_r >= last);
endmodule // sacc_clk_div

/* File: src/sacc_skid_buf.sv */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module sacc_skid_buf #(
	parameter int unsigned WIDTH = 10
) (
	input  wire logic             core_clk_i,
	input  wire logic             nrst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	logic [WIDTH-1:0] mem_r [2];
	logic             wp_r;
	logic             rp_r;
	logic [1:0]       cnt_r;
	logic             push;
	logic             pop;

	initial begin
		if (WIDTH < 1) begin
			$error("sacc_skid_buf: WIDTH must be at least 1");
		end
	end

	assign in_ready_o  = (cnt_r != 2'h2);
	assign out_valid_o = (cnt_r != 2'h0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign out_data_o  = mem_r[rp_r];

	// Storage array; contents need no reset because valid guards them.
	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_r[wp_r] <= in_data_i;
		end
	end

	// Pointers and fill count.
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			wp_r  <= 1'b0;
			rp_r  <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			if (push) begin
				wp_r <= ~wp_r;
			end
			if (pop) begin
				rp_r <= ~rp_r;
			end
			cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // sacc_skid_buf

/* File: src/sacc_top.sv */
// Conversion control for the successive approximation converter.
//
// Function
// - One SAR engine, 10-bit results, resolution selectable as 8 or 10 bits.
// - Eight modes: one-shot, repeat, sweeps, multi-port sweeps and self test.
// - Input selector addresses 26 inputs: three ports of eight plus two extended.
// - Software trigger selected: setting the start bit begins conversion at once.
// - External trigger: each falling pin edge after start bit set starts, retrigger allowed.
// - Hardware trigger: timer A0 or divided timer B2 request starts, retrigger allowed.
// - Without sample-and-hold: 49 or 59 cycles per input, 2 sampling.
// - With sample-and-hold: 28 or 33 cycles per input, 3 sampling.
// - Converter clock divider chosen by three select bits: /1,/2,/3,/4,/6,/8.
// - DMA mode stores every result in the first result register only.
// - A control rewrite during conversion makes that result undefined.
// - Channel field only in single modes; sweep width only in sweep modes.
// - Clearing reference-connect bit disconnects reference from the ladder.
// - One-shot completion raises an interrupt request.
// - Software one-shot completion clears the start bit.
`timescale 1ns/1ps
module sacc_top #(
	parameter int unsigned RES_W = sacc_pkg::RES_W
) (
	input  wire logic             core_clk_i,
	input  wire logic             nrst_i,
	// Start bit and trigger control.
	input  wire logic             conv_start_set_i,
	input  wire logic             conv_start_clr_i,
	output logic                  conv_start_bit_o,
	input  wire logic             trigger_source_sel_i,
	input  wire logic             hw_trigger_sel_hi_i,
	input  wire logic             hw_trigger_sel_lo_i,
	input  wire logic             ext_trigger_pin_i,
	input  wire logic             tmr_a0_irq_i,
	input  wire logic             tmr_b2_div_irq_i,
	// Mode and selection.
	input  wire logic             op_mode_hi_i,
	input  wire logic             op_mode_lo_i,
	input  wire logic             sweep_mode1_bit_i,
	input  wire logic             multiport_sweep_en_i,
	input  wire logic             self_test_en_i,
	input  wire logic [2:0]       channel_sel_i,
	input  wire logic             sweep_width_hi_i,
	input  wire logic             sweep_width_lo_i,
	input  wire logic             port_group_sel_hi_i,
	input  wire logic             port_group_sel_lo_i,
	input  wire logic             ext_input_sel_hi_i,
	input  wire logic             ext_input_sel_lo_i,
	input  wire logic             multiport_group_hi_i,
	input  wire logic             multiport_group_lo_i,
	input  wire logic             res_10bit_i,
	input  wire logic             sample_hold_en_i,
	input  wire logic             dma_mode_bit_i,
	input  wire logic             ref_connect_bit_i,
	input  wire logic             clk_div_sel_a_i,
	input  wire logic             clk_div_sel_b_i,
	input  wire logic             clk_div_sel_c_i,
	input  wire logic             ctrl_write_i,
	// Analog front end.
	output logic [4:0]            ain_sel_o,
	output logic                  sample_o,
	output logic [RES_W-1:0]      dac_code_o,
	input  wire logic             cmp_i,
	output logic                  ref_connect_o,
	// Results, status and DMA stream.
	input  wire logic [2:0]       result_rd_idx_i,
	output logic [RES_W-1:0]      result_rd_o,
	output logic                  result_undef_o,
	output logic [2:0]            active_mode_o,
	output logic                  busy_o,
	output logic                  conv_irq_o,
	output logic                  dma_valid_o,
	input  wire logic             dma_ready_i,
	output logic [RES_W-1:0]      dma_data_o
);
	sacc_pkg::sacc_state_e state_r;
	sacc_pkg::sacc_mode_e  mode;
	logic [RES_W-1:0] res_r [sacc_pkg::PORT_PINS];
	logic [RES_W-1:0] sar_r;
	logic [3:0]       bit_r;
	logic [5:0]       cyc_r;
	logic [2:0]       chan_r;
	logic             pass_r;
	logic             start_r;
	logic             pin_q_r;
	logic             undef_r;
	logic             irq_r;
	logic             rd_undef_r;
	logic             tick;
	logic             trig;
	logic             sw_go;
	logic             last_chan;
	logic             buf_ready;
	logic             store_ok;
	logic [5:0]       cyc_total;
	logic [5:0]       cyc_samp;
	logic [2:0]       chan_last;
	logic             single;
	logic             repeat_any;
	logic [1:0]       grp;

	initial begin
		if (RES_W != 10) begin
			$error("sacc_top: the engine serves only 10-bit results");
		end
	end

	sacc_clk_div u_div (
		.core_clk_i      (core_clk_i),
		.nrst_i          (nrst_i),
		.clk_div_sel_a_i (clk_div_sel_a_i),
		.clk_div_sel_b_i (clk_div_sel_b_i),
		.clk_div_sel_c_i (clk_div_sel_c_i),
		.tick_o          (tick)
	);

	// Mode decode: multi-port and sweep mode 1 override the two-bit field.
	always_comb begin
		if (self_test_en_i) begin
			mode = sacc_pkg::MODE_SELFTEST;
		end else if (multiport_sweep_en_i) begin
			mode = op_mode_lo_i ? sacc_pkg::MODE_MP_RSW0 : sacc_pkg::MODE_MP_SWEEP;
		end else if (sweep_mode1_bit_i) begin
			mode = sacc_pkg::MODE_RSWEEP1;
		end else begin
			unique case ({op_mode_hi_i, op_mode_lo_i})
				sacc_pkg::MD_ONE_SHOT: mode = sacc_pkg::MODE_ONE_SHOT;
				sacc_pkg::MD_REPEAT:   mode = sacc_pkg::MODE_REPEAT;
				sacc_pkg::MD_SWEEP:    mode = sacc_pkg::MODE_SWEEP;
				sacc_pkg::MD_RSWEEP:   mode = sacc_pkg::MODE_RSWEEP0;
			endcase
		end
	end

	// Self test behaves as a single conversion of the internal test node.
	assign single     = (mode == sacc_pkg::MODE_ONE_SHOT) || (mode == sacc_pkg::MODE_REPEAT) ||
	                    (mode == sacc_pkg::MODE_SELFTEST);
	assign repeat_any = (mode == sacc_pkg::MODE_REPEAT) || (mode == sacc_pkg::MODE_RSWEEP0) ||
	                    (mode == sacc_pkg::MODE_RSWEEP1) || (mode == sacc_pkg::MODE_MP_RSW0);
	assign chan_last  = {sweep_width_hi_i, sweep_width_lo_i, 1'b1};
	assign last_chan  = single || (chan_r == chan_last);
	assign grp        = (multiport_sweep_en_i && pass_r) ?
	                    {multiport_group_hi_i, multiport_group_lo_i} :
	                    {port_group_sel_hi_i, port_group_sel_lo_i};

	// Cycle budget per input; sampling is part of the total.
	always_comb begin
		if (sample_hold_en_i) begin
			cyc_total = res_10bit_i ? 6'(sacc_pkg::CYC_10B_SH) : 6'(sacc_pkg::CYC_8B_SH);
			cyc_samp  = 6'(sacc_pkg::SAMP_SH);
		end else begin
			cyc_total = res_10bit_i ? 6'(sacc_pkg::CYC_10B_NOSH) : 6'(sacc_pkg::CYC_8B_NOSH);
			cyc_samp  = 6'(sacc_pkg::SAMP_NOSH);
		end
	end

	// Input selector: port group times eight plus channel, or an extended input.
	always_comb begin
		if (mode == sacc_pkg::MODE_SELFTEST) begin
			ain_sel_o = sacc_pkg::SELF_TEST_IDX;
		end else if (single && ext_input_sel_lo_i && !ext_input_sel_hi_i) begin
			ain_sel_o = sacc_pkg::EXT_IN_0_IDX;
		end else if (single && ext_input_sel_hi_i && !ext_input_sel_lo_i) begin
			ain_sel_o = sacc_pkg::EXT_IN_1_IDX;
		end else begin
			ain_sel_o = {grp, chan_r};
		end
	end

	// Triggers: software start, falling pin edge, or a timer request.
	assign sw_go = conv_start_set_i && !trigger_source_sel_i;
	always_comb begin
		unique case ({hw_trigger_sel_hi_i, hw_trigger_sel_lo_i})
			sacc_pkg::TRG_EXT_PIN: trig = pin_q_r && !ext_trigger_pin_i;
			sacc_pkg::TRG_TMR_B2:  trig = tmr_b2_div_irq_i;
			sacc_pkg::TRG_TMR_A0:  trig = tmr_a0_irq_i;
			default:               trig = 1'b0;
		endcase
	end

	// Pin history for the edge detector; the pin is taken as synchronous.
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			pin_q_r <= 1'b1;
		end else begin
			pin_q_r <= ext_trigger_pin_i;
		end
	end

	// In DMA mode a full buffer holds the store so no result is lost.
	assign store_ok = !dma_mode_bit_i || buf_ready;

	// Start bit: software set and clear, hardware clear at the end of a finite software-triggered run.
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			start_r <= 1'b0;
		end else if (conv_start_set_i) begin
			start_r <= 1'b1;
		end else if (conv_start_clr_i) begin
			start_r <= 1'b0;
		end else if (state_r == sacc_pkg::ST_STORE && store_ok && last_chan && !repeat_any &&
		             !trigger_source_sel_i && (!multiport_sweep_en_i || pass_r)) begin
			start_r <= 1'b0;
		end
	end

	// Sequencer. A trigger during conversion restarts the current sequence.
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || conv_start_clr_i) begin
			state_r <= sacc_pkg::ST_IDLE;
			chan_r  <= 3'h0;
			pass_r  <= 1'b0;
			cyc_r   <= 6'h00;
		end else if (sw_go || (start_r && trigger_source_sel_i && trig)) begin
			state_r <= sacc_pkg::ST_SAMPLE;
			chan_r  <= single ? channel_sel_i : 3'h0;
			pass_r  <= 1'b0;
			cyc_r   <= 6'h00;
		end else begin
			unique case (state_r)
				sacc_pkg::ST_IDLE: begin
					if (conv_start_set_i) begin
						state_r <= sacc_pkg::ST_ARMED;
					end
				end
				sacc_pkg::ST_ARMED: begin
					state_r <= sacc_pkg::ST_ARMED;
				end
				sacc_pkg::ST_SAMPLE: begin
					if (tick) begin
						cyc_r <= cyc_r + 6'h01;
						if (cyc_r + 6'h01 == cyc_samp) begin
							state_r <= sacc_pkg::ST_CONV;
						end
					end
				end
				sacc_pkg::ST_CONV: begin
					if (tick) begin
						cyc_r <= cyc_r + 6'h01;
						if (cyc_r + 6'h01 == cyc_total) begin
							state_r <= sacc_pkg::ST_STORE;
						end
					end
				end
				sacc_pkg::ST_STORE: begin
					if (store_ok) begin
						cyc_r <= 6'h00;
						if (!last_chan) begin
							chan_r  <= chan_r + 3'h1;
							state_r <= sacc_pkg::ST_SAMPLE;
						end else if (multiport_sweep_en_i && !pass_r) begin
							chan_r  <= 3'h0;
							pass_r  <= 1'b1;
							state_r <= sacc_pkg::ST_SAMPLE;
						end else if (repeat_any) begin
							chan_r  <= single ? channel_sel_i : 3'h0;
							pass_r  <= 1'b0;
							state_r <= sacc_pkg::ST_SAMPLE;
						end else begin
							state_r <= trigger_source_sel_i ? sacc_pkg::ST_ARMED :
							           sacc_pkg::ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Successive approximation: one bit trial per converter tick after sampling.
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || state_r == sacc_pkg::ST_SAMPLE) begin
			sar_r <= '0;
			bit_r <= res_10bit_i ? 4'h9 : 4'h7;
		end else if (state_r == sacc_pkg::ST_CONV && tick && bit_r != 4'hF) begin
			sar_r[bit_r] <= cmp_i;
			bit_r        <= bit_r - 4'h1;
		end
	end

	assign dac_code_o    = (state_r == sacc_pkg::ST_CONV && bit_r != 4'hF) ?
	                       (sar_r | (RES_W'(1) << bit_r)) : sar_r;
	assign sample_o      = (state_r == sacc_pkg::ST_SAMPLE);
	assign ref_connect_o = ref_connect_bit_i;
	assign busy_o        = (state_r == sacc_pkg::ST_SAMPLE) || (state_r == sacc_pkg::ST_CONV) ||
	                       (state_r == sacc_pkg::ST_STORE);

	// A control write while busy taints the result in flight.
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || state_r == sacc_pkg::ST_SAMPLE && cyc_r == 6'h00 && !ctrl_write_i) begin
			undef_r <= 1'b0;
		end else if (busy_o && ctrl_write_i) begin
			undef_r <= 1'b1;
		end
	end

	// Result store: pin's own register, or only the first one in DMA mode.
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < int'(sacc_pkg::PORT_PINS); i++) begin
				res_r[i] <= '0;
			end
		end else if (state_r == sacc_pkg::ST_STORE && store_ok) begin
			res_r[dma_mode_bit_i ? 3'h0 : chan_r] <= sar_r;
		end
	end

	// Registered read port; the flag reports a tainted last store.
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			result_rd_o <= '0;
			rd_undef_r  <= 1'b0;
		end else begin
			result_rd_o <= res_r[result_rd_idx_i];
			if (state_r == sacc_pkg::ST_STORE && store_ok) begin
				rd_undef_r <= undef_r;
			end
		end
	end

	// Interrupt pulse per conversion in DMA mode, else at each one-shot or sweep end; none in repeat mode.
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= state_r == sacc_pkg::ST_STORE && store_ok &&
			         (dma_mode_bit_i || (last_chan && (!repeat_any || !single) &&
			          (!multiport_sweep_en_i || pass_r)));
		end
	end

	// The DMA path is 10 bits wide; the controller moves it as 16-bit words.
	sacc_skid_buf #(
		.WIDTH (RES_W)
	) u_buf (
		.core_clk_i  (core_clk_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (state_r == sacc_pkg::ST_STORE && dma_mode_bit_i),
		.in_ready_o  (buf_ready),
		.in_data_i   (sar_r),
		.out_valid_o (dma_valid_o),
		.out_ready_i (dma_ready_i),
		.out_data_o  (dma_data_o)
	);

	assign conv_start_bit_o = start_r;
	assign result_undef_o   = rd_undef_r;
	assign active_mode_o    = mode;
	assign conv_irq_o       = irq_r;
endmodule // sacc_top

/* File: sim/sacc_top_asserts.sv */
// Port-level assertions for the converter control block.
`timescale 1ns/1ps
module sacc_top_asserts #(
	parameter int unsigned RES_W = 10
) (
	input wire logic             core_clk_i,
	input wire logic             nrst_i,
	input wire logic             conv_start_set_i,
	input wire logic             conv_start_bit_o,
	input wire logic             trigger_source_sel_i,
	input wire logic             dma_mode_bit_i,
	input wire logic             sample_hold_en_i,
	input wire logic             ref_connect_bit_i,
	input wire logic             clk_div_sel_a_i,
	input wire logic             clk_div_sel_b_i,
	input wire logic             clk_div_sel_c_i,
	input wire logic             sample_o,
	input wire logic             ref_connect_o,
	input wire logic [2:0]       active_mode_o,
	input wire logic             busy_o,
	input wire logic             conv_irq_o,
	input wire logic             dma_valid_o,
	input wire logic             dma_ready_i,
	input wire logic [RES_W-1:0] dma_data_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	// Sampling lengths are only exact in cycles when every clock is a converter tick.
	logic div1;
	assign div1 = !clk_div_sel_c_i && clk_div_sel_a_i && clk_div_sel_b_i;
	a_irq_one_cycle: assert property (conv_irq_o |=> !conv_irq_o)
		else $error("irq longer than one cycle");
	a_ref_follows: assert property (ref_connect_o == ref_connect_bit_i)
		else $error("reference switch does not follow its bit");
	a_sw_start_now: assert property (conv_start_set_i && !trigger_source_sel_i && !busy_o
		|=> busy_o && sample_o) else $error("software start not immediate");
	a_idle_stays: assert property (!busy_o && !conv_start_bit_o && !conv_start_set_i
		|=> !busy_o) else $error("conversion without start bit");
	a_sample_two: assert property ($rose(sample_o) && div1 && !sample_hold_en_i
		|-> sample_o [*2] ##1 !sample_o) else $error("sampling not two cycles");
	a_sample_three: assert property ($rose(sample_o) && div1 && sample_hold_en_i
		|-> sample_o [*3] ##1 !sample_o) else $error("sampling not three cycles");
	a_start_clears: assert property (conv_irq_o && !trigger_source_sel_i && !dma_mode_bit_i
		&& active_mode_o == 3'h0 |-> !conv_start_bit_o) else $error("start bit kept");
	a_stream_hold: assert property (dma_valid_o && !dma_ready_i
		|=> dma_valid_o && $stable(dma_data_o)) else $error("stream word dropped");
	a_start_held: assert property (busy_o && !trigger_source_sel_i |-> conv_start_bit_o)
		else $error("start bit low during a software run");
	c_irq: cover property (conv_irq_o);
	c_stall: cover property (dma_valid_o && !dma_ready_i);
	c_trig: cover property ($rose(busy_o) && trigger_source_sel_i);
endmodule // sacc_top_asserts
bind sacc_top sacc_top_asserts #(.RES_W(RES_W)) u_chk (
	.core_clk_i, .nrst_i, .conv_start_set_i, .conv_start_bit_o, .trigger_source_sel_i,
	.dma_mode_bit_i, .sample_hold_en_i, .ref_connect_bit_i, .clk_div_sel_a_i, .clk_div_sel_b_i,
	.clk_div_sel_c_i, .sample_o, .ref_connect_o, .active_mode_o, .busy_o, .conv_irq_o,
	.dma_valid_o, .dma_ready_i, .dma_data_o
);

/* File: sim/sacc_afe_model.sv */
// Behavioural analog front end and stream sink facing the converter block.
`timescale 1ns/1ps
module sacc_afe_model (
	input  wire logic       core_clk_i,
	input  wire logic [4:0] ain_sel_i,
	input  wire logic       sample_i,
	input  wire logic [9:0] dac_code_i,
	output logic            cmp_o,
	input  wire logic       stall_i,
	output logic            dma_ready_o,
	output logic [4:0]      last_sel_o
);
	logic [9:0] lvl[32];
	logic [9:0] held = 10'h000;
	logic [1:0] cnt = 2'h0;
	// The level moves only while sampling, so the trials always meet a steady input.
	always @(posedge core_clk_i) begin
		if (sample_i) begin
			held <= lvl[ain_sel_i];
			last_sel_o <= ain_sel_i;
		end
		cnt <= cnt + 2'h1;
	end
	// A trial bit is kept while the input is at or above the trial code.
	assign cmp_o = (dac_code_i <= held);
	// The sink is slow on purpose: two cycles ready in four, none while stalled.
	assign dma_ready_o = !stall_i && cnt[1];
endmodule // sacc_afe_model

/* File: sim/sacc_top_test.sv */
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value %s exp %0h got %0h", nm, e, g); end end
module sacc_top_test;
	logic       clk = 0, nrst = 0, set = 0, clr = 0, tsrc = 0, pin = 1, ta0 = 0, tb2 = 0, s;
	logic       sw1 = 0, multiport_sweep_en = 0, st = 0, r10 = 1, sh = 0, dma = 0, ref_c = 0, wr = 0, stall = 0;
	logic [1:0] hw = 2'h3, md = 2'h0, wid = 2'h0, xs = 2'h0;
	logic [2:0] ch = 3'h0, dv = 3'h3, idx = 3'h0, mode;
	logic       sbit, sample_hold_en, cmp, refo, und, busy, irq, dvld, drdy;
	logic [4:0] ain, lsel;
	logic [9:0] dac, rd, ddat, e;
	int         num_errors = 0, num_checks = 0, seed = 32'hf3e0, d, i, k;
	logic [9:0] eq[$];
	logic [4:0] mtab[8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h07, 5'h0A, 5'h0B, 5'h10};
	sacc_top DUT (
		.core_clk_i(clk), .nrst_i(nrst), .conv_start_set_i(set), .conv_start_clr_i(clr),
		.conv_start_bit_o(sbit), .trigger_source_sel_i(tsrc), .hw_trigger_sel_hi_i(hw[1]),
		.hw_trigger_sel_lo_i(hw[0]), .ext_trigger_pin_i(pin), .tmr_a0_irq_i(ta0),
		.tmr_b2_div_irq_i(tb2), .op_mode_hi_i(md[1]), .op_mode_lo_i(md[0]),
		.sweep_mode1_bit_i(sw1), .multiport_sweep_en_i(multiport_sweep_en), .self_test_en_i(st),
		.channel_sel_i(ch), .sweep_width_hi_i(wid[1]), .sweep_width_lo_i(wid[0]),
		.port_group_sel_hi_i(1'b0), .port_group_sel_lo_i(multiport_sweep_en),
		.ext_input_sel_hi_i(xs[1]), .ext_input_sel_lo_i(xs[0]),
		.multiport_group_hi_i(multiport_sweep_en), .multiport_group_lo_i(1'b0),
		.res_10bit_i(r10), .sample_hold_en_i(sh), .dma_mode_bit_i(dma),
		.ref_connect_bit_i(ref_c), .clk_div_sel_a_i(dv[1]), .clk_div_sel_b_i(dv[0]),
		.clk_div_sel_c_i(dv[2]), .ctrl_write_i(wr), .ain_sel_o(ain), .sample_o(sample_hold_en),
		.dac_code_o(dac), .cmp_i(cmp), .ref_connect_o(refo), .result_rd_idx_i(idx),
		.result_rd_o(rd), .result_undef_o(und), .active_mode_o(mode), .busy_o(busy),
		.conv_irq_o(irq), .dma_valid_o(dvld), .dma_ready_i(drdy), .dma_data_o(ddat)
	);
	sacc_afe_model afe (
		.core_clk_i(clk), .ain_sel_i(ain), .sample_i(sample_hold_en), .dac_code_i(dac), .cmp_o(cmp),
		.stall_i(stall), .dma_ready_o(drdy), .last_sel_o(lsel)
	);
	// Clock at 40 MHz.
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic tick();
		@(posedge clk);
		#2;
	endtask
	task automatic final_report();
		if (num_errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic wait_irq(output int n);
		n = 0;
		while (irq !== 1'b1 && n < 5000) begin
			tick();
			n++;
		end
		if (n >= 5000) begin
			num_errors++;
			final_report();
		end
	endtask
	task automatic conv(output int n);
		set = 1;
		tick();
		set = 0;
		wait_irq(n);
	endtask
	task automatic fire(input int n);
		if (n == 0) pin = 0;
		else if (n == 1) ta0 = 1;
		else tb2 = 1;
		tick();
		{pin, ta0, tb2} = 3'h4;
	endtask
	// Watches a few cycles for any sampling, since a trigger may be synchronised first.
	task automatic watch(output logic v);
		v = 0;
		repeat (4) begin
			tick();
			v |= sample_hold_en;
		end
	endtask
	function automatic int dfac(logic [2:0] c);
		case (c)
			3'h0: return 4;
			3'h1: return 3;
			3'h2: return 2;
			3'h3: return 1;
			3'h5: return 6;
			default: return 8;
		endcase
	endfunction
	// Each word taken from the stream is matched against the oldest expected level.
	always @(posedge clk) begin
		if (nrst && dma && dvld === 1'b1 && drdy) begin
			e = (eq.size() > 0) ? eq.pop_front() : ~ddat;
			`CHK("dma_data", e, ddat)
		end
	end
	initial begin
		for (i = 0; i < 32; i++) begin
			afe.lvl[i] = 10'($random(seed));
		end
		repeat (5) tick();
		nrst = 1;
		`CHK("start_bit", 1'b0, sbit)
		`CHK("ref", 1'b0, refo)
		ref_c = 1;
		repeat (40) tick();
		for (i = 0; i < 8; i++) begin
			{st, multiport_sweep_en, sw1, md} = mtab[i];
			tick();
			`CHK("mode", 3'(i), mode)
		end
		{st, multiport_sweep_en, sw1, md} = 5'h00;
		for (i = 0; i < 4; i++) begin
			{r10, sh} = 2'(i);
			ch = 3'($random(seed));
			conv(d);
			k = sh ? (r10 ? 33 : 28) : (r10 ? 59 : 49);
			`CHK("duration", 1'b1, d >= k - 1 && d <= k + 8)
			`CHK("start_bit", 1'b0, sbit)
			`CHK("input", {2'h0, ch}, lsel)
			idx = ch;
			tick();
			if (r10) `CHK("result", afe.lvl[ch], rd)
		end
		for (i = 0; i < 6; i++) begin
			dv = 3'(i);
			conv(d);
			k = dfac(dv);
			`CHK("div_time", 1'b1, d >= 32 * k && d <= 36 * k + 6)
		end
		dv = 3'h3;
		{md, wid, ch} = 7'h4E;
		conv(d);
		for (i = 0; i < 4; i++) begin
			idx = 3'(i);
			tick();
			`CHK("sweep_result", afe.lvl[i], rd)
		end
		{md, ch} = 5'h05;
		conv(d);
		idx = 3'h1;
		tick();
		`CHK("held_result", afe.lvl[1], rd)
		xs = 2'h1;
		conv(d);
		`CHK("ext_input", 5'h18, lsel)
		xs = 2'h0;
		// Self test converts the internal node; sample-and-hold is still on here.
		st = 1;
		conv(d);
		`CHK("self_test", 5'h1F, lsel)
		st = 0;
		set = 1;
		tick();
		set = 0;
		repeat (5) tick();
		wr = 1;
		tick();
		wr = 0;
		wait_irq(d);
		tick();
		`CHK("undef", 1'b1, und)
		conv(d);
		tick();
		`CHK("undef", 1'b0, und)
		tsrc = 1;
		for (k = 0; k < 3; k++) begin
			hw = (k == 0) ? 2'h0 : (k == 1) ? 2'h2 : 2'h1;
			fire(k);
			watch(s);
			`CHK("idle_trigger", 1'b0, s)
			set = 1;
			tick();
			set = 0;
			watch(s);
			`CHK("armed_sample", 1'b0, s)
			fire(k);
			repeat (10) tick();
			fire(k);
			wait_irq(d);
			`CHK("retrigger", 1'b1, d > 25)
			clr = 1;
			tick();
			clr = 0;
		end
		{tsrc, hw} = 3'h3;
		// The sink stalls while the sweep fills the two-entry buffer, then drains it.
		{dma, stall, md} = 4'hE;
		for (i = 0; i < 4; i++) begin
			eq.push_back(afe.lvl[i]);
		end
		conv(d);
		repeat (150) tick();
		`CHK("stalled_valid", 1'b1, dvld)
		stall = 0;
		for (i = 0; i < 4000 && eq.size() > 0; i++) begin
			tick();
		end
		`CHK("drained", 0, eq.size())
		idx = 3'h0;
		repeat (2) tick();
		`CHK("dma_reg0", afe.lvl[3], rd)
		// Multi-port single sweep: group 1 then group 2, so inputs 8 to 23 in order.
		{multiport_sweep_en, wid} = 3'h7;
		for (i = 0; i < 16; i++) begin
			eq.push_back(afe.lvl[8 + i]);
		end
		conv(d);
		`CHK("mp_mode", 3'h5, mode)
		for (i = 0; i < 4000 && eq.size() > 0; i++) begin
			tick();
		end
		`CHK("mp_drained", 0, eq.size())
		`CHK("mp_start_bit", 1'b0, sbit)
		final_report();
	end
endmodule // sacc_top_test
